// *** verilog/port_caps_pkg.sv ***
// Shared constants for the port status and link capability register slice
package port_caps_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] DEVICE_ERROR_STATUS_OFS = 8'hC8;
  localparam logic [7:0] LINK_CAPABILITIES_OFS = 8'hCC;

  // ----------------------------------------
  // Status dword fields
  // ----------------------------------------
  localparam int ERR_FLAG_LSB = 16;
  localparam int ERR_FLAG_CNT = 4;
  localparam int AUX_PWR_BIT = 20;
  localparam int TRANS_PEND_BIT = 21;
  localparam int ERR_BYTE_LANE = 2;
  localparam logic AUX_PWR_RST = 1'h1;

  // ----------------------------------------
  // Link capability fields
  // ----------------------------------------
  localparam int SPEED_LSB = 0;
  localparam int WIDTH_LSB = 4;
  localparam int ASPM_LSB = 10;
  localparam int L0S_LSB = 12;
  localparam int L1_LSB = 15;
  localparam int CLKPM_BIT = 18;
  localparam int SURPRISE_BIT = 19;
  localparam int DLL_ACT_BIT = 20;
  localparam int BW_NOTIFY_BIT = 21;
  localparam int PORT_NUM_LSB = 24;

  // ----------------------------------------
  // Link capability reset values
  // ----------------------------------------
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [3:0] SPEED_5G0 = 4'h2;
  localparam logic [3:0] SPEED_RST = SPEED_5G0;
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [1:0] ASPM_RST = 2'h0;
  localparam logic [2:0] L0S_RST = 3'h3;
  localparam logic [2:0] L1_RST = 3'h0;
  localparam logic CLKPM_UP_RST = 1'h1;
  localparam logic SURPRISE_RST = 1'h0;
  localparam logic BW_NOTIFY_RST = 1'h0;
  localparam logic [2:0] UPSTREAM_PORT_IDX = 3'h0;
  localparam int PORT_COUNT = 6;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

endpackage

// *** verilog/error_flag_bank.sv ***
// Sticky write-one-to-clear error flags, one per error class
`timescale 1ns/1ps
module error_flag_bank #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Events and clears
  input wire logic [N-1:0] i_set,
  input wire logic [N-1:0] i_clr,
  // Flags
  output logic [N-1:0] o_flag
);

  if (N < 1 || N > 8) begin : g_bad_n
    $error("error_flag_bank: N out of range");
  end

  typedef struct packed {
    logic [N-1:0] flag;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------
  // Per-flag update: set beats clear
  // ----------------------------------------
  always_comb begin
    next_st = st;
    for (int k = 0; k < N; k++) begin
      next_st.flag[k] = i_set[k] | (st.flag[k] & ~i_clr[k]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_flag = st.flag;

endmodule

// *** verilog/link_cap_store.sv ***
// Link capability image: strap defaults plus external override loads
`timescale 1ns/1ps
module link_cap_store (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Default load from captured straps
  input wire logic i_load,
  input wire logic i_upstream,
  input wire logic i_four_lane,
  input wire logic [7:0] i_port_num,
  // Override from serial management or autoload
  input wire logic i_ovr_we,
  input wire logic [31:0] i_ovr_data,
  // Capability image
  output logic [31:0] o_cap
);

  typedef struct packed {
    logic [7:0] port_num;
    logic bw_notify;
    logic dll_act;
    logic surprise;
    logic clkpm;
    logic [2:0] l1;
    logic [2:0] l0s;
    logic [1:0] aspm;
    logic [5:0] width;
    logic [3:0] speed;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------
  // Defaults, then overrides of writable fields
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (i_load) begin
      next_st.speed = port_caps_pkg::SPEED_RST;
      next_st.width = (i_upstream && i_four_lane) ? port_caps_pkg::WIDTH_X4 : port_caps_pkg::WIDTH_X1;
      next_st.aspm = port_caps_pkg::ASPM_RST;
      next_st.l0s = port_caps_pkg::L0S_RST;
      next_st.l1 = port_caps_pkg::L1_RST;
      next_st.clkpm = i_upstream ? port_caps_pkg::CLKPM_UP_RST : 1'h0;
      next_st.surprise = port_caps_pkg::SURPRISE_RST;
      next_st.dll_act = ~i_upstream;
      next_st.bw_notify = port_caps_pkg::BW_NOTIFY_RST;
      next_st.port_num = i_port_num;
    end else if (i_ovr_we) begin
      next_st.aspm = i_ovr_data[port_caps_pkg::ASPM_LSB +: 2];
      next_st.l0s = i_ovr_data[port_caps_pkg::L0S_LSB +: 3];
      next_st.l1 = i_ovr_data[port_caps_pkg::L1_LSB +: 3];
      // Downstream ports keep clock PM hardwired low
      next_st.clkpm = i_upstream & i_ovr_data[port_caps_pkg::CLKPM_BIT];
      next_st.surprise = i_ovr_data[port_caps_pkg::SURPRISE_BIT];
      next_st.bw_notify = i_ovr_data[port_caps_pkg::BW_NOTIFY_BIT];
      next_st.port_num = i_ovr_data[port_caps_pkg::PORT_NUM_LSB +: 8];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st.speed <= port_caps_pkg::SPEED_RST;
      st.width <= port_caps_pkg::WIDTH_X1;
      st.aspm <= port_caps_pkg::ASPM_RST;
      st.l0s <= port_caps_pkg::L0S_RST;
      st.l1 <= port_caps_pkg::L1_RST;
      st.clkpm <= 1'h0;
      st.surprise <= port_caps_pkg::SURPRISE_RST;
      st.dll_act <= 1'h0;
      st.bw_notify <= port_caps_pkg::BW_NOTIFY_RST;
      st.port_num <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // Reserved bits 23:22 read as zero
  assign o_cap = {st.port_num, 2'h0, st.bw_notify, st.dll_act, st.surprise, st.clkpm,
                  st.l1, st.l0s, st.aspm, st.width, st.speed};

endmodule

// *** verilog/port_status_link_caps.sv ***
// Per-port error status and link capability configuration registers
`timescale 1ns/1ps
// Behaviour
// - Correctable error sets status bit 16; write one clears; resets zero.
// - Non-fatal error sets status bit 17; write one clears; resets zero.
// - Fatal error sets status bit 18; write one clears; resets zero.
// - Unsupported request sets status bit 19; write one clears; resets zero.
// - Error logging ignores the reporting enables of device control.
// - Status bit 20 shows auxiliary power present; resets to one.
// - Transactions-pending bit 21 always reads zero.
// - Max link speed bits 3:0 reset to the 5.0 Gb/s code.
// - Max width x4 on four-lane upstream port, otherwise x1.
// - ASPM support bits 11:10 read-only, reset zero.
// - L0s exit latency bits 14:12 reset to code three.
// - L1 exit latency bits 17:15 reset to code zero.
// - Capability defaults except speed, width, data link active and downstream clock PM replaceable by serial management or autoload loads.
// - Clock PM bit 18 one on upstream after reset, zero downstream.
// - Data link active reporting bit 20 one downstream, zero upstream.
// - Port number bits 31:24 reset to the port index, clamped to the last port.
module port_status_link_caps #(
  parameter logic [2:0] PORT_INDEX_MAX = 3'h5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Configuration access
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  // Error detection pulses from port logic
  input wire logic i_err_correctable,
  input wire logic i_err_nonfatal,
  input wire logic i_err_fatal,
  input wire logic i_err_unsupported,
  // Device control reporting enables, not used for logging
  input wire logic [3:0] i_err_report_en,
  // Auxiliary power sense pin
  input wire logic i_aux_power,
  // Port straps
  input wire logic [2:0] i_port_index,
  input wire logic i_four_lane_mode,
  // Capability override load
  input wire logic i_cap_override_we,
  input wire logic [31:0] i_cap_override_data,
  // Status to port logic
  output logic [3:0] o_err_flags,
  output logic [31:0] o_link_caps
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (int'(PORT_INDEX_MAX) >= port_caps_pkg::PORT_COUNT) begin : g_bad_index_max
    $error("port_status_link_caps: PORT_INDEX_MAX exceeds port count");
  end
  if (int'(port_caps_pkg::UPSTREAM_PORT_IDX) > int'(PORT_INDEX_MAX)) begin : g_bad_upstream
    $error("port_status_link_caps: upstream index beyond last port");
  end
  if (port_caps_pkg::ERR_FLAG_CNT != 4) begin : g_bad_flag_cnt
    $error("port_status_link_caps: four error flags expected");
  end
  if ((port_caps_pkg::ERR_FLAG_LSB / 8) != port_caps_pkg::ERR_BYTE_LANE) begin : g_bad_lane
    $error("port_status_link_caps: flag field outside its byte lane");
  end
  if (port_caps_pkg::ERR_FLAG_LSB + port_caps_pkg::ERR_FLAG_CNT > port_caps_pkg::AUX_PWR_BIT) begin : g_bad_overlap
    $error("port_status_link_caps: flag field overlaps aux power bit");
  end
  if (port_caps_pkg::TRANS_PEND_BIT > 31) begin : g_bad_pend
    $error("port_status_link_caps: pending bit outside the dword");
  end

  // ----------------------------------------
  // Capability image layout checks
  // ----------------------------------------
  // The image is packed field by field, so the positions must abut
  if (port_caps_pkg::SPEED_LSB + 4 != port_caps_pkg::WIDTH_LSB) begin : g_bad_width_pos
    $error("port_status_link_caps: width field misplaced");
  end
  if (port_caps_pkg::WIDTH_LSB + 6 != port_caps_pkg::ASPM_LSB) begin : g_bad_aspm_pos
    $error("port_status_link_caps: power management field misplaced");
  end
  if (port_caps_pkg::ASPM_LSB + 2 != port_caps_pkg::L0S_LSB) begin : g_bad_l0s_pos
    $error("port_status_link_caps: L0s latency field misplaced");
  end
  if (port_caps_pkg::L0S_LSB + 3 != port_caps_pkg::L1_LSB) begin : g_bad_l1_pos
    $error("port_status_link_caps: L1 latency field misplaced");
  end
  if (port_caps_pkg::L1_LSB + 3 != port_caps_pkg::CLKPM_BIT) begin : g_bad_clkpm_pos
    $error("port_status_link_caps: clock PM bit misplaced");
  end
  if (port_caps_pkg::CLKPM_BIT + 3 != port_caps_pkg::BW_NOTIFY_BIT) begin : g_bad_flag_pos
    $error("port_status_link_caps: single-bit capability fields misplaced");
  end
  if (port_caps_pkg::PORT_NUM_LSB + 8 != 32) begin : g_bad_port_pos
    $error("port_status_link_caps: port number field misplaced");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  typedef struct packed {
    // Strap synchronisers and settle count
    logic [2:0] idx_meta;
    logic [2:0] idx_sync;
    logic lane_meta;
    logic lane_sync;
    logic [1:0] settle;
    // Straps as captured once
    logic loaded;
    logic upstream;
    logic four_lane;
    logic [7:0] port_num;
    // Auxiliary power synchroniser
    logic aux_meta;
    logic aux_sync;
    // Access answer
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  logic [3:0] err_events;
  logic [3:0] err_clear;
  logic [3:0] err_flags;

  logic [31:0] link_caps;
  logic [31:0] status_word;
  logic [31:0] read_word;

  logic hit_status;
  logic wr_status;
  logic flag_lane_en;

  logic strap_ready;
  logic cap_load;
  logic cap_ovr_we;
  logic unused_report_en;

  // ----------------------------------------
  // Port index clamp
  // ----------------------------------------
  // Out-of-range strap codes map to the last port
  function automatic logic [7:0] clamp_port(input logic [2:0] idx);
    logic [2:0] lim;
    lim = (idx > PORT_INDEX_MAX) ? PORT_INDEX_MAX : idx;
    return {5'h00, lim};
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign hit_status = (i_cfg_addr == port_caps_pkg::DEVICE_ERROR_STATUS_OFS);
  assign wr_status = i_cfg_wr & hit_status;
  assign flag_lane_en = i_cfg_be[port_caps_pkg::ERR_BYTE_LANE];

  // ----------------------------------------
  // Error logging
  // ----------------------------------------
  // Reporting enables deliberately play no part here
  assign unused_report_en = ^i_err_report_en;
  assign err_events = {i_err_unsupported, i_err_fatal, i_err_nonfatal, i_err_correctable};

  // Only written ones in the flag byte lane clear a flag
  for (genvar g = 0; g < port_caps_pkg::ERR_FLAG_CNT; g++) begin : g_clear
    assign err_clear[g] = wr_status & flag_lane_en & i_cfg_wdata[port_caps_pkg::ERR_FLAG_LSB + g];
  end

  error_flag_bank #(
    .N(port_caps_pkg::ERR_FLAG_CNT)
  ) u_err_flags (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_set(err_events),
    .i_clr(err_clear),
    .o_flag(err_flags)
  );

  // ----------------------------------------
  // Capability load strobes
  // ----------------------------------------
  // Straps are read only once both synchroniser stages hold pin values
  assign strap_ready = (st.settle == port_caps_pkg::STRAP_SETTLE_CYCLES);
  assign cap_load = strap_ready & ~st.loaded;
  // Overrides wait until the defaults are in place
  assign cap_ovr_we = i_cap_override_we & st.loaded;

  // ----------------------------------------
  // Link capability image
  // ----------------------------------------
  link_cap_store u_caps (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_load(cap_load),
    .i_upstream(next_st.upstream),
    .i_four_lane(next_st.four_lane),
    .i_port_num(next_st.port_num),
    .i_ovr_we(cap_ovr_we),
    .i_ovr_data(i_cap_override_data),
    .o_cap(link_caps)
  );

  // ----------------------------------------
  // Status word composition
  // ----------------------------------------
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[port_caps_pkg::ERR_FLAG_LSB +: port_caps_pkg::ERR_FLAG_CNT] = err_flags;
    status_word[port_caps_pkg::AUX_PWR_BIT] = st.aux_sync;
    status_word[port_caps_pkg::TRANS_PEND_BIT] = 1'h0;
  end

  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  always_comb begin
    read_word = 32'h0000_0000;
    case (i_cfg_addr)
      port_caps_pkg::DEVICE_ERROR_STATUS_OFS: begin
        read_word = status_word;
      end
      port_caps_pkg::LINK_CAPABILITIES_OFS: begin
        read_word = link_caps;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------
  // Strap capture, pin sync, access answer
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Two stages before any logic reads a strap
    next_st.idx_meta = i_port_index;
    next_st.idx_sync = st.idx_meta;
    next_st.lane_meta = i_four_lane_mode;
    next_st.lane_sync = st.lane_meta;
    if (!strap_ready) begin
      next_st.settle = st.settle + 2'h1;
    end
    // Straps are caught once per reset
    if (cap_load) begin
      next_st.loaded = 1'h1;
      next_st.upstream = (st.idx_sync == port_caps_pkg::UPSTREAM_PORT_IDX);
      next_st.four_lane = st.lane_sync;
      next_st.port_num = clamp_port(st.idx_sync);
    end
    // Auxiliary power pin
    next_st.aux_meta = i_aux_power;
    next_st.aux_sync = st.aux_meta;
    // Answer one cycle after every request
    next_st.ack = i_cfg_rd | i_cfg_wr;
    next_st.rdata = i_cfg_rd ? read_word : 32'h0000_0000;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // Strap capture restarts after every reset
      st.idx_meta <= 3'h0;
      st.idx_sync <= 3'h0;
      st.lane_meta <= 1'h0;
      st.lane_sync <= 1'h0;
      st.settle <= 2'h0;
      st.loaded <= 1'h0;
      st.upstream <= 1'h0;
      st.four_lane <= 1'h0;
      st.port_num <= 8'h00;
      st.aux_meta <= port_caps_pkg::AUX_PWR_RST;
      st.aux_sync <= port_caps_pkg::AUX_PWR_RST;
      st.ack <= 1'h0;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_cfg_ack = st.ack;
  assign o_cfg_rdata = st.rdata;
  assign o_err_flags = err_flags;
  assign o_link_caps = link_caps;

endmodule

// *** dv/port_status_link_caps_chk.sv ***
// Concurrent checks for the status and link capability slice
`timescale 1ns/1ps
module port_status_link_caps_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Watched ports
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic o_cfg_ack,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic i_err_correctable,
  input wire logic i_err_nonfatal,
  input wire logic i_err_fatal,
  input wire logic i_err_unsupported,
  input wire logic [3:0] o_err_flags,
  input wire logic [31:0] o_link_caps
);
  logic [3:0] ev;
  logic [3:0] clr_hit;
  logic [3:0] keep;
  logic [3:0] drop;
  assign ev = {i_err_unsupported, i_err_fatal, i_err_nonfatal, i_err_correctable};
  assign clr_hit = (i_cfg_wr && i_cfg_addr == 8'hC8 && i_cfg_be[2]) ? i_cfg_wdata[19:16] : 4'h0;
  assign keep = o_err_flags & ~clr_hit;
  assign drop = clr_hit & ~ev;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_req;
    i_cfg_rd || i_cfg_wr;
  endsequence
  sequence s_cap_rd;
    i_cfg_rd && i_cfg_addr == 8'hCC;
  endsequence
  a_ack_follows: assert property (s_req |=> o_cfg_ack)
    else $error("no answer after request");
  a_err_set: assert property (ev != 4'h0 |=> (o_err_flags & $past(ev)) == $past(ev))
    else $error("error event not logged");
  a_flag_hold: assert property (1'b1 |=> (o_err_flags & $past(keep)) == $past(keep))
    else $error("flag lost without clear");
  a_flag_clear: assert property (1'b1 |=> (o_err_flags & $past(drop)) == 4'h0)
    else $error("flag not cleared");
  a_flag_cause: assert property (1'b1 |=> (o_err_flags & ~$past(o_err_flags) & ~$past(ev)) == 4'h0)
    else $error("flag set without event");
  a_status_rsvd: assert property (i_cfg_rd && i_cfg_addr == 8'hC8 |=> o_cfg_rdata[31:21] == 11'h0)
    else $error("status upper bits not zero");
  a_unmapped_zero: assert property (i_cfg_rd && i_cfg_addr != 8'hC8 && i_cfg_addr != 8'hCC |=> o_cfg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_caps_read: assert property (s_cap_rd |=> o_cfg_ack && o_cfg_rdata == $past(o_link_caps))
    else $error("caps read differs from image");
  a_speed_fixed: assert property (o_link_caps[3:0] == 4'h2 && o_link_caps[23:22] == 2'h0)
    else $error("speed or reserved caps bits wrong");
endmodule
bind port_status_link_caps port_status_link_caps_chk u_chk (.i_clk, .i_rst_b, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr,
  .i_cfg_be, .i_cfg_wdata, .o_cfg_ack, .o_cfg_rdata, .i_err_correctable, .i_err_nonfatal, .i_err_fatal,
  .i_err_unsupported, .o_err_flags, .o_link_caps);

// *** dv/testbench.sv ***
// Self-checking bench for the status and link capability slice
`timescale 1ns/1ps
module testbench;
  logic i_clk = 0, i_rst_b = 0, i_cfg_rd = 0, i_cfg_wr = 0, i_aux_power = 1, i_four_lane_mode = 0;
  logic i_cap_override_we = 0, exp_aux = 1, o_cfg_ack;
  logic [7:0] i_cfg_addr = 8'h00;
  logic [3:0] i_cfg_be = 4'h0, i_err_report_en = 4'h0, ev = 4'h0, exp_flags = 4'h0, o_err_flags;
  logic [31:0] i_cfg_wdata = 32'h0, i_cap_override_data = 32'h0, exp_caps, ovr, o_cfg_rdata, o_link_caps;
  logic [2:0] i_port_index = 3'h0, idx;
  logic [32:0] q[$];
  logic [32:0] e;
  wire logic i_err_correctable, i_err_nonfatal, i_err_fatal, i_err_unsupported;
  int bad_count = 0, check_count = 0;
  assign {i_err_unsupported, i_err_fatal, i_err_nonfatal, i_err_correctable} = ev;
  port_status_link_caps u_port_status_link_caps (.i_clk, .i_rst_b, .i_cfg_rd, .i_cfg_wr, .i_cfg_addr, .i_cfg_be,
    .i_cfg_wdata, .o_cfg_ack, .o_cfg_rdata, .i_err_correctable, .i_err_nonfatal, .i_err_fatal, .i_err_unsupported,
    .i_err_report_en, .i_aux_power, .i_port_index, .i_four_lane_mode, .i_cap_override_we, .i_cap_override_data,
    .o_err_flags, .o_link_caps);
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Answer monitor
  // ----------------------------------------
  always @(negedge i_clk) begin
    if (o_cfg_ack === 1'b1) begin
      if (q.size() == 0) check(o_cfg_rdata, 32'hFFFFFFFF);
      else begin
        e = q.pop_front();
        if (e[32]) check(o_cfg_rdata, e[31:0]);
      end
    end
  end
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task step(input logic rd, wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
    input logic [3:0] er);
    logic [3:0] clr;
    @(negedge i_clk);
    check({28'h0, o_err_flags}, {28'h0, exp_flags});
    if (rd) q.push_back({1'b1, a == 8'hC8 ? {11'h0, exp_aux, exp_flags, 16'h0} : a == 8'hCC ? exp_caps : 32'h0});
    else if (wr) q.push_back({1'b1, 32'h0});
    clr = (wr && a == 8'hC8 && be[2]) ? wd[19:16] : 4'h0;
    exp_flags = (exp_flags & ~clr) | er;
    i_cfg_rd = rd;
    i_cfg_wr = wr;
    i_cfg_addr = a;
    i_cfg_be = be;
    i_cfg_wdata = wd;
    ev = er;
    i_err_report_en = 4'($urandom);
  endtask
  task do_reset(input logic fl);
    logic [7:0] pn;
    @(negedge i_clk);
    i_rst_b = 0;
    i_port_index = idx;
    i_four_lane_mode = fl;
    exp_flags = 4'h0;
    repeat (20) @(negedge i_clk);
    check(o_link_caps, 32'h00003012);
    check({28'h0, o_err_flags}, 32'h0);
    i_rst_b = 1;
    pn = idx > 3'h5 ? 8'h05 : {5'h0, idx};
    exp_caps = {pn, 3'h0, idx != 3'h0, 1'b0, idx == 3'h0, 3'h0, 3'h3, 2'h0, (idx == 3'h0 && fl) ? 6'h04 : 6'h01, 4'h2};
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(69589));
    for (int k = 0; k < 9; k++) begin
      idx = 3'(k);
      do_reset(k[3] | k[0]);
      repeat (3) step(0, 0, 8'h00, 4'h0, 32'h0, 4'h0);
      check(o_link_caps, exp_caps);
      step(1, 0, 8'hCC, 4'hF, 32'h0, 4'h0);
      step(0, 1, 8'hCC, 4'hF, $urandom, 4'h0);
      step(0, 0, 8'h00, 4'h0, 32'h0, 4'h0);
      ovr = $urandom;
      i_cap_override_data = ovr;
      i_cap_override_we = 1;
      exp_caps = (exp_caps & ~32'hFF2FFC00) | (ovr & 32'hFF2BFC00) | (idx == 3'h0 ? ovr & 32'h00040000 : 32'h0);
      @(negedge i_clk);
      i_cap_override_we = 0;
      check(o_link_caps, exp_caps);
      for (int j = 0; j < 16; j++) begin
        step(j[0], ~j[0], j[1] ? 8'hC8 : 8'($urandom), 4'($urandom), $urandom, 4'($urandom));
      end
      step(1, 0, 8'hCC, 4'hF, 32'h0, 4'h0);
      step(0, 0, 8'h00, 4'h0, 32'h0, 4'h0);
    end
    @(negedge i_clk);
    i_aux_power = 0;
    repeat (4) step(0, 0, 8'h00, 4'h0, 32'h0, 4'h0);
    exp_aux = 0;
    step(1, 0, 8'hC8, 4'hF, 32'h0, 4'h0);
    repeat (2) step(0, 0, 8'h00, 4'h0, 32'h0, 4'h0);
    @(posedge i_clk);
    check(q.size(), 32'h0);
    report_and_stop();
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule
